// ==== design/smc_sleep_ctrl.v ====
// Sleep mode controller: entry, clock gating, wake and halt sequence
// What this block does
// - Sleep entered only when enable bit set and sleep instruction executes.
// - After wake, core halted four cycles beyond start-up, then resumes.
// - Register file and SRAM kept intact; only clocks gated, no clear.
// - Reset during sleep wakes device and restarts at reset vector.
// - Mode 000 Idle: stop CPU and flash clocks; all wake sources.
// - Entering Idle or quiet mode starts a conversion if converter enabled.
// - Mode 001 quiet: stop CPU, flash, I/O clocks; converter, async run.
// - Quiet mode wakes only on the listed converter-mode sources.
// - Mode 010 Power-down: oscillator and all generated clocks stop.
// - Power-down wakes only on reset, watchdog, address match, pins, pin change.
// - Outside Idle, external irq pins wake only when level triggered.
// - Power-down wake waits the start-up delay set by clock source fuses.
// - Mode 011 Power-save: like Power-down, timer 2 may wake if enabled.
// - Power-save stops timer osc or main clock per timer 2 clocking.
// - Mode 110 Standby: Power-down with oscillator kept if crystal, then six-cycle wake.
// - Mode 111 Extended Standby: Power-save with oscillator kept if crystal, then six cycles.
// - Mode field bits 3..1, enable bit 0, all reset to zero.
// - Sleep instruction enters sleep only with enable bit one.
`timescale 1ns/1ps
`default_nettype none
`include "smc_consts.vh"

module smc_sleep_ctrl (
    // Clock and reset
    input wire clk,
    input wire srst,
    // Sleep control register write port
    input wire ctrl_wr,
    input wire [7:0] ctrl_wdata,
    output wire [7:0] sleep_control_reg,
    // Core handshake
    input wire sleep_instr,
    input wire crystal_clock,
    input wire [15:0] clock_source_fuses,
    output reg core_halt_q,
    output reg resume_q,
    output reg sleeping_q,
    // Peripheral configuration
    input wire adc_enabled,
    input wire t2_enabled,
    input wire t2_async,
    input wire t2_sync,
    // Wake requests
    input wire ext_irq_level,
    input wire ext_irq_edge,
    input wire pin_change_irq,
    input wire twi_addr_match,
    input wire twi_irq,
    input wire timer2_irq,
    input wire timer2_irq_mask,
    input wire global_irq_en,
    input wire spm_ready_irq,
    input wire adc_done_irq,
    input wire wdt_irq,
    input wire other_io_irq,
    // Clock and oscillator gates, converter start
    output reg [4:0] clk_run_q,
    output reg main_osc_en_q,
    output reg timer_osc_en_q,
    output reg adc_start_q,
    output reg [2:0] active_mode_q
);

    localparam ST_RUN = 2'h0;
    localparam ST_SLEEP = 2'h1;
    localparam ST_START = 2'h2;
    localparam ST_HALT = 2'h3;

    reg sleep_enable_bit_q;
    reg [2:0] sleep_mode_select_q;
    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [15:0] cnt_q;
    reg [15:0] cnt_d;
    wire wake;

    // Reserved modes reject sleep entry
    function mode_valid;
        input [2:0] m;
        begin
            mode_valid = (m != `SMC_MODE_RSVD4) && (m != `SMC_MODE_RSVD5);
        end
    endfunction

    // Oscillator-kept group: Idle, quiet, and both standby modes with crystal
    function osc_kept;
        input [2:0] m;
        input xtal;
        begin
            osc_kept = (m == `SMC_MODE_IDLE) || (m == `SMC_MODE_QUIET) ||
                       (((m == `SMC_MODE_STBY) || (m == `SMC_MODE_XSTBY)) && xtal);
        end
    endfunction

    assign sleep_control_reg = {4'h0, sleep_mode_select_q, sleep_enable_bit_q};

    smc_wake_filter u_filter (
        .mode(active_mode_q),
        .t2_async(t2_async),
        .ext_irq_level(ext_irq_level),
        .ext_irq_edge(ext_irq_edge),
        .pin_change_irq(pin_change_irq),
        .twi_addr_match(twi_addr_match),
        .twi_irq(twi_irq),
        .timer2_irq(timer2_irq),
        .timer2_irq_mask(timer2_irq_mask),
        .global_irq_en(global_irq_en),
        .spm_ready_irq(spm_ready_irq),
        .adc_done_irq(adc_done_irq),
        .wdt_irq(wdt_irq),
        .other_io_irq(other_io_irq),
        .wake(wake)
    );

    // Control register
    always @(posedge clk) begin
        if (srst) begin
            sleep_enable_bit_q <= 1'b0;
            sleep_mode_select_q <= 3'h0;
        end else if (ctrl_wr) begin
            sleep_enable_bit_q <= ctrl_wdata[`SMC_SE_BIT];
            sleep_mode_select_q <= ctrl_wdata[`SMC_MODE_MSB:`SMC_MODE_LSB];
        end
    end

    // Sequencer next state
    always @* begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            ST_RUN: begin
                if (sleep_instr && sleep_enable_bit_q && mode_valid(sleep_mode_select_q)) begin
                    state_d = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (wake) begin
                    if (osc_kept(active_mode_q, crystal_clock)) begin
                        state_d = ST_START;
                        cnt_d = ((active_mode_q == `SMC_MODE_STBY) ||
                                 (active_mode_q == `SMC_MODE_XSTBY)) ?
                                `SMC_STBY_WAKE_CYCLES : 16'h0001;
                    end else begin
                        state_d = ST_START;
                        cnt_d = (clock_source_fuses == 16'h0000) ? 16'h0001 :
                                clock_source_fuses;
                    end
                end
            end
            ST_START: begin
                if (cnt_q <= 16'h0001) begin
                    state_d = ST_HALT;
                    cnt_d = {12'h000, `SMC_HALT_CYCLES};
                end else begin
                    cnt_d = cnt_q - 16'h0001;
                end
            end
            ST_HALT: begin
                if (cnt_q <= 16'h0001) begin
                    state_d = ST_RUN;
                    cnt_d = 16'h0000;
                end else begin
                    cnt_d = cnt_q - 16'h0001;
                end
            end
            default: begin
                state_d = ST_RUN;
                cnt_d = 16'h0000;
            end
        endcase
    end

    // Sequencer registers and gated outputs; memories never touched here
    always @(posedge clk) begin
        if (srst) begin
            state_q <= ST_RUN;
            cnt_q <= 16'h0000;
            core_halt_q <= 1'b0;
            resume_q <= 1'b0;
            sleeping_q <= 1'b0;
            clk_run_q <= 5'h1F;
            main_osc_en_q <= 1'b1;
            timer_osc_en_q <= 1'b1;
            adc_start_q <= 1'b0;
            active_mode_q <= 3'h0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            resume_q <= (state_q == ST_HALT) && (state_d == ST_RUN);
            sleeping_q <= (state_d == ST_SLEEP);
            core_halt_q <= (state_d != ST_RUN);
            adc_start_q <= 1'b0;
            if (state_q == ST_RUN && state_d == ST_SLEEP) begin
                active_mode_q <= sleep_mode_select_q;
                if ((sleep_mode_select_q == `SMC_MODE_IDLE ||
                     sleep_mode_select_q == `SMC_MODE_QUIET) && adc_enabled) begin
                    adc_start_q <= 1'b1;
                end
            end
            if (state_d == ST_SLEEP) begin
                case (state_q == ST_RUN ? sleep_mode_select_q : active_mode_q)
                    `SMC_MODE_IDLE: begin
                        clk_run_q <= 5'h1C;
                        main_osc_en_q <= 1'b1;
                        timer_osc_en_q <= t2_async;
                    end
                    `SMC_MODE_QUIET: begin
                        clk_run_q <= 5'h18;
                        main_osc_en_q <= 1'b1;
                        timer_osc_en_q <= t2_async;
                    end
                    `SMC_MODE_PSAVE: begin
                        clk_run_q <= {t2_enabled & t2_async, 4'h0};
                        main_osc_en_q <= t2_enabled & t2_sync;
                        timer_osc_en_q <= t2_enabled & t2_async;
                    end
                    `SMC_MODE_STBY: begin
                        clk_run_q <= 5'h00;
                        main_osc_en_q <= crystal_clock;
                        timer_osc_en_q <= 1'b0;
                    end
                    `SMC_MODE_XSTBY: begin
                        clk_run_q <= {t2_enabled & t2_async, 4'h0};
                        main_osc_en_q <= crystal_clock | (t2_enabled & t2_sync);
                        timer_osc_en_q <= t2_enabled & t2_async;
                    end
                    default: begin
                        clk_run_q <= 5'h00;
                        main_osc_en_q <= 1'b0;
                        timer_osc_en_q <= 1'b0;
                    end
                endcase
            end else begin
                clk_run_q <= (state_d == ST_RUN) ? 5'h1F : {4'hE, 1'b0};
                main_osc_en_q <= 1'b1;
                timer_osc_en_q <= 1'b1;
            end
        end
    end

endmodule // smc_sleep_ctrl
`default_nettype wire

// ==== design/smc_consts.vh ====
// Constants for the sleep mode controller
`ifndef SMC_CONSTS_VH
`define SMC_CONSTS_VH

// Sleep control register layout
`define SMC_CTRL_WIDTH 8
`define SMC_SE_BIT 0
`define SMC_MODE_LSB 1
`define SMC_MODE_MSB 3
`define SMC_CTRL_RESET 8'h00

// Mode codes
`define SMC_MODE_IDLE 3'h0
`define SMC_MODE_QUIET 3'h1
`define SMC_MODE_PDOWN 3'h2
`define SMC_MODE_PSAVE 3'h3
`define SMC_MODE_RSVD4 3'h4
`define SMC_MODE_RSVD5 3'h5
`define SMC_MODE_STBY 3'h6
`define SMC_MODE_XSTBY 3'h7

// Timing
`define SMC_HALT_CYCLES 4'h4
`define SMC_STBY_WAKE_CYCLES 16'h0006
`define SMC_CNT_WIDTH 16

// Clock gate vector bit positions
`define SMC_CLK_CPU 0
`define SMC_CLK_FLASH 1
`define SMC_CLK_IO 2
`define SMC_CLK_ADC 3
`define SMC_ASYNC_TIMER_CLOCK 4

`endif

// ==== design/smc_wake_filter.v ====
// Wake source qualifier for the selected sleep mode
`timescale 1ns/1ps
`default_nettype none
`include "smc_consts.vh"

module smc_wake_filter (
    // Selected mode
    input wire [2:0] mode,
    input wire t2_async,
    // Wake requests
    input wire ext_irq_level,
    input wire ext_irq_edge,
    input wire pin_change_irq,
    input wire twi_addr_match,
    input wire twi_irq,
    input wire timer2_irq,
    input wire timer2_irq_mask,
    input wire global_irq_en,
    input wire spm_ready_irq,
    input wire adc_done_irq,
    input wire wdt_irq,
    input wire other_io_irq,
    // Qualified wake
    output reg wake
);

    reg t2_ok;

    always @* begin
        t2_ok = timer2_irq & timer2_irq_mask & global_irq_en;
        case (mode)
            `SMC_MODE_IDLE: begin
                wake = ext_irq_level | ext_irq_edge | pin_change_irq | twi_addr_match |
                       twi_irq | timer2_irq | spm_ready_irq | adc_done_irq | wdt_irq |
                       other_io_irq;
            end
            `SMC_MODE_QUIET: begin
                wake = adc_done_irq | wdt_irq | twi_irq | twi_addr_match |
                       (timer2_irq & t2_async) | spm_ready_irq | pin_change_irq |
                       ext_irq_level;
            end
            `SMC_MODE_PDOWN, `SMC_MODE_STBY: begin
                wake = twi_addr_match | ext_irq_level | pin_change_irq | wdt_irq;
            end
            `SMC_MODE_PSAVE, `SMC_MODE_XSTBY: begin
                wake = twi_addr_match | ext_irq_level | pin_change_irq | wdt_irq | t2_ok;
            end
            default: begin
                wake = 1'b0;
            end
        endcase
    end

endmodule // smc_wake_filter
`default_nettype wire

// ==== tb/smc_sleep_ctrl_properties.sv ====
// Concurrent checks on the sleep mode controller ports
`timescale 1ns/1ps
`default_nettype none
module smc_sleep_ctrl_props (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Control and status
    input wire logic [7:0] sleep_control_reg,
    input wire logic sleep_instr,
    input wire logic crystal_clock,
    input wire logic adc_enabled,
    input wire logic core_halt_q,
    input wire logic resume_q,
    input wire logic sleeping_q,
    input wire logic [4:0] clk_run_q,
    input wire logic main_osc_en_q,
    input wire logic adc_start_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    wire [2:0] mode = sleep_control_reg[3:1];
    wire go = sleep_instr && !core_halt_q;
    wire ok = go && sleep_control_reg[0];
    sequence s_halt_run;
        core_halt_q [*4] ##[0:40] resume_q;
    endsequence
    a_refuse_off: assert property (go && !sleep_control_reg[0] |=> !sleeping_q)
        else $error("sleep entered with enable clear");
    a_refuse_rsvd: assert property (go && mode[2:1] == 2'h2 |=> !sleeping_q)
        else $error("sleep entered on reserved mode");
    a_enter_sleep: assert property (ok && mode[2:1] != 2'h2 |=> sleeping_q && core_halt_q)
        else $error("sleep not entered");
    a_idle_clocks: assert property (ok && mode == 3'h0 |=> clk_run_q == 5'h1C)
        else $error("idle clock gating wrong");
    a_quiet_clocks: assert property (ok && mode == 3'h1 |=> clk_run_q[3:0] == 4'h8)
        else $error("quiet clock gating wrong");
    a_pdown_clocks: assert property (ok && mode == 3'h2 |=> !clk_run_q && !main_osc_en_q)
        else $error("power down left a clock running");
    a_stby_osc: assert property (ok && mode[2:1] == 2'h3 && crystal_clock |=> main_osc_en_q)
        else $error("standby stopped the oscillator");
    a_adc_start: assert property (ok && mode[2:1] == 2'h0 && adc_enabled |=> adc_start_q)
        else $error("no conversion start on entry");
    a_halt_four: assert property ($fell(sleeping_q) |-> s_halt_run)
        else $error("halt tail wrong after wake");
    a_reg_reset: assert property ($past(srst) |-> sleep_control_reg == 8'h00)
        else $error("control register not cleared");
endmodule // smc_sleep_ctrl_props
`default_nettype wire

// ==== tb/smc_wake_model.sv ====
// Wake source model: raised requests are held until the core wakes
`timescale 1ns/1ps
`default_nettype none
module smc_wake_model (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Request pulses and core state
    input wire logic [9:0] raise,
    input wire logic sleeping_q,
    // Level requests
    output logic [9:0] irq_q
);
    always @(posedge clk) begin
        irq_q <= srst ? 10'h000 : (irq_q | raise) & {10{sleeping_q}};
    end
endmodule // smc_wake_model
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the sleep mode controller
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 0, srst = 1, ctrl_wr = 0, sleep_instr = 0, crystal_clock = 0;
    logic adc_enabled = 0, t2_async = 0, t2_sync = 1;
    logic [7:0] ctrl_wdata = 8'h00;
    logic [15:0] clock_source_fuses = 16'h0014;
    logic [9:0] raise = 10'h000;
    wire [9:0] irq;
    wire [7:0] sleep_control_reg;
    wire [4:0] clk_run_q;
    wire [2:0] active_mode_q;
    wire core_halt_q, resume_q, sleeping_q, main_osc_en_q, timer_osc_en_q, adc_start_q;
    int fails = 0, checks_done = 0, cyc = 0;
    smc_sleep_ctrl DUT (.clk, .srst, .ctrl_wr, .ctrl_wdata, .sleep_control_reg, .sleep_instr,
        .crystal_clock, .clock_source_fuses, .core_halt_q, .resume_q, .sleeping_q,
        .adc_enabled, .t2_enabled(1'b1), .t2_async, .t2_sync,
        .ext_irq_level(irq[0]), .ext_irq_edge(irq[1]), .pin_change_irq(irq[2]),
        .twi_addr_match(irq[3]), .twi_irq(irq[4]), .timer2_irq(irq[5]),
        .timer2_irq_mask(1'b1), .global_irq_en(1'b1), .spm_ready_irq(irq[6]),
        .adc_done_irq(irq[7]), .wdt_irq(irq[8]), .other_io_irq(irq[9]), .clk_run_q,
        .main_osc_en_q, .timer_osc_en_q, .adc_start_q, .active_mode_q);
    smc_wake_model u_wake (.clk, .srst, .raise, .sleeping_q, .irq_q(irq));
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fails++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic sleep_in(input logic [2:0] m, input logic en);
        @(negedge clk) ctrl_wr = 1;
        ctrl_wdata = {4'h0, m, en};
        @(negedge clk) ctrl_wr = 0;
        sleep_instr = 1;
        @(negedge clk) sleep_instr = 0;
    endtask
    task automatic wake(input int src, input int n);
        int c;
        @(negedge clk) raise = 10'(1) << src;
        @(negedge clk) raise = 10'h000;
        c = 1;
        while (resume_q !== 1'b1 && c < 200) begin
            @(negedge clk);
            c++;
        end
        check(c >= n + 4 && c <= n + 8, 1);
    endtask
    task automatic no_wake(input int src);
        @(negedge clk) raise = 10'(1) << src;
        @(negedge clk) raise = 10'h000;
        repeat (8) @(negedge clk);
        check(sleeping_q, 1);
    endtask
    task automatic t_reset();
        check(sleep_control_reg, 8'h00);
        check({core_halt_q, clk_run_q}, 6'h1F);
    endtask
    task automatic t_refuse();
        sleep_in(3'h0, 0);
        check(sleeping_q, 0);
        sleep_in(3'h4, 1);
        check(sleeping_q, 0);
        sleep_in(3'h5, 1);
        check({sleeping_q, core_halt_q}, 0);
    endtask
    task automatic t_idle_quiet();
        adc_enabled = 1;
        sleep_in(3'h0, 1);
        check({adc_start_q, clk_run_q}, 6'h3C);
        wake(9, 1);
        sleep_in(3'h1, 1);
        check({adc_start_q, clk_run_q[3:0]}, 5'h18);
        no_wake(9);
        wake(7, 1);
    endtask
    task automatic t_pdown();
        adc_enabled = 0;
        sleep_in(3'h2, 1);
        check({adc_start_q, main_osc_en_q, clk_run_q}, 0);
        check(active_mode_q, 3'h2);
        no_wake(5);
        no_wake(1);
        wake(0, 20);
        check(sleep_control_reg, 8'h05);
    endtask
    task automatic t_psave_stby();
        t2_async = 1;
        t2_sync = 0;
        sleep_in(3'h3, 1);
        check({timer_osc_en_q, clk_run_q}, 6'h30);
        check({main_osc_en_q, timer_osc_en_q, clk_run_q}, 7'h30);
        wake(5, 20);
        crystal_clock = 1;
        sleep_in(3'h6, 1);
        check({main_osc_en_q, clk_run_q}, 6'h20);
        wake(3, 6);
        sleep_in(3'h7, 1);
        check(main_osc_en_q, 1);
        wake(5, 6);
    endtask
    task automatic t_rst_sleep();
        sleep_in(3'h2, 1);
        @(negedge clk) srst = 1;
        repeat (2) @(negedge clk);
        srst = 0;
        check({sleeping_q, core_halt_q, sleep_control_reg}, 0);
    endtask
    initial begin
        repeat (2) @(negedge clk);
        srst = 0;
        t_reset();
        t_refuse();
        t_idle_quiet();
        t_pdown();
        t_psave_stby();
        t_rst_sleep();
        print_verdict();
    end
endmodule // tb
bind smc_sleep_ctrl smc_sleep_ctrl_props u_props (.*);
`default_nettype wire
